// *** verilog/led_pulse_ctrl.sv ***
// Purpose: Digital core of a boost LED driver: pulse-coded brightness,
//          enable dimming and shutdown, protection gating, AHB-Lite regs.
// Assumes: Comparator inputs carry their own analog hysteresis.
// Notes:   Registers answer with no wait states and always OKAY.
`timescale 1ns/1ns
module led_pulse_ctrl
  import led_pkg::*;
#(
  parameter int DN_MIN  = DN_MIN_CYC,
  parameter int DN_MAX  = DN_MAX_CYC,
  parameter int DIS_MIN = DIS_MIN_CYC,
  parameter int SHUT    = SHUT_CYC
) (
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // AHB-Lite slave.
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // Pins and comparators.
  input  wire logic              i_brightness_program_pin,
  input  wire logic              i_enable_pin,
  input  wire logic              i_output_overvoltage_guard,
  input  wire logic              i_undervoltage,
  input  wire logic              i_over_temperature,
  // Power stage and reference.
  output logic [TGT_W-1:0]       o_feedback_target_level,
  output logic                   o_switch_gate_en,
  output logic                   o_power_switches_off,
  output logic                   o_led_current_on
);

  localparam int LOW_W  = $clog2(DIS_MIN + 1);
  localparam int SHUT_W = $clog2(SHUT + 1);
  localparam int NPIN   = 5;

  // Input filtering, one lane per asynchronous input.
  pin_sync_if pins [NPIN] ();
  logic [NPIN-1:0] raw_in;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;

  assign raw_in = {i_over_temperature, i_undervoltage,
                   i_output_overvoltage_guard, i_enable_pin,
                   i_brightness_program_pin};

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    assign pins[g].raw = raw_in[g];
    assign lvl[g]      = pins[g].level;
    assign rise[g]     = pins[g].rise;
    pin_filter u_filt (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .pin     (pins[g])
    );
  end

  logic prog_lvl;
  logic prog_rise;
  logic en_lvl;
  logic ovp_lvl;
  logic uvlo_lvl;
  logic hot_lvl;

  assign prog_lvl  = lvl[0];
  assign prog_rise = rise[0];
  assign en_lvl    = lvl[1];
  assign ovp_lvl   = lvl[2];
  assign uvlo_lvl  = lvl[3];
  assign hot_lvl   = lvl[4];

  // Register state.
  logic [1:0]        ctrl_r;
  logic [7:0]        up_cnt_r;
  logic [7:0]        dn_cnt_r;
  logic [7:0]        ign_cnt_r;

  // Core state.
  logic              active_r;
  logic [SHUT_W-1:0] shut_cnt_r;
  logic [LOW_W-1:0]  low_cnt_r;
  logic              dig_en_r;
  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] code_nxt;
  step_t             step;
  logic              dis_hit;

  // Classify a finished low pulse by its width in cycles.
  function automatic step_t classify(input logic [LOW_W-1:0] w);
    if (32'(w) >= UP_MIN_CYC && 32'(w) <= UP_MAX_CYC) begin
      classify = STEP_UP;
    end else if (32'(w) >= DN_MIN && 32'(w) <= DN_MAX) begin
      classify = STEP_DOWN;
    end else begin
      classify = STEP_NONE;
    end
  endfunction : classify

  // Enable low, or hold-off set, for the full timeout shuts down; a high with hold-off clear restarts.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      shut_cnt_r <= '0;
      active_r   <= 1'b0;
    end else if (en_lvl && !ctrl_r[CTRL_HOLD_OFF_BIT]) begin
      shut_cnt_r <= '0;
      active_r   <= 1'b1;
    end else if (32'(shut_cnt_r) >= SHUT - 1) begin
      active_r   <= 1'b0;
    end else begin
      shut_cnt_r <= shut_cnt_r + SHUT_W'(1);
    end
  end

  // Width of the current low phase, held at the disable threshold.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      low_cnt_r <= '0;
    end else if (prog_lvl) begin
      if (!prog_rise) begin
        low_cnt_r <= '0;
      end
    end else if (32'(low_cnt_r) < DIS_MIN) begin
      low_cnt_r <= low_cnt_r + LOW_W'(1);
    end
  end

  // Low counter holds the finished width during the rise strobe.
  assign dis_hit = !prog_lvl && (32'(low_cnt_r) >= DIS_MIN);
  assign step    = (prog_rise && dig_en_r && !ctrl_r[CTRL_LOCK_BIT])
                   ? classify(low_cnt_r) : STEP_NONE;

  always_comb begin
    code_nxt = code_r;
    case (step)
      STEP_UP: begin
        if (code_r != CODE_MAX) begin
          code_nxt = code_r + CODE_W'(1);
        end
      end
      STEP_DOWN: begin
        if (code_r != CODE_MIN) begin
          code_nxt = code_r - CODE_W'(1);
        end
      end
      STEP_NONE: begin
        code_nxt = code_r;
      end
      default: begin
        code_nxt = code_r;
      end
    endcase
  end

  // Brightness mode and code; shutdown returns them to reset state.
  always_ff @(posedge i_clk) begin
    if (i_reset || !active_r) begin
      dig_en_r <= 1'b0;
      code_r   <= CODE_MID;
    end else if (dis_hit) begin
      dig_en_r <= 1'b0;
      code_r   <= CODE_MID;
    end else if (!dig_en_r && prog_lvl) begin
      dig_en_r <= 1'b1;
      code_r   <= CODE_MID;
    end else begin
      code_r   <= code_nxt;
    end
  end

  // Step statistics, saturating, for software visibility.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      up_cnt_r  <= '0;
      dn_cnt_r  <= '0;
      ign_cnt_r <= '0;
    end else if (prog_rise && dig_en_r && active_r) begin
      if (step == STEP_UP && up_cnt_r != 8'hff) begin
        up_cnt_r <= up_cnt_r + 8'h01;
      end else if (step == STEP_DOWN && dn_cnt_r != 8'hff) begin
        dn_cnt_r <= dn_cnt_r + 8'h01;
      end else if (step == STEP_NONE && ign_cnt_r != 8'hff) begin
        ign_cnt_r <= ign_cnt_r + 8'h01;
      end
    end
  end

  // Power stage outputs, registered.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_feedback_target_level <= TGT_FULL;
      o_switch_gate_en        <= 1'b0;
      o_power_switches_off    <= 1'b1;
      o_led_current_on        <= 1'b0;
    end else begin
      o_feedback_target_level <= dig_en_r ? {1'b0, code_r} : TGT_FULL;
      o_led_current_on        <= active_r && en_lvl;
      // Overvoltage only pauses pulses; clearing it restarts them.
      o_switch_gate_en        <= active_r && en_lvl && !ovp_lvl
                                 && !uvlo_lvl && !hot_lvl;
      o_power_switches_off    <= !active_r || uvlo_lvl
                                 || hot_lvl;
    end
  end

  // AHB-Lite slave: capture the address phase, act in the data phase.
  logic       dp_wr_r;
  logic [7:0] dp_ofs_r;
  logic       ap_take;
  logic [7:0] ap_ofs;
  logic [31:0] status_w;

  assign ap_take = i_hsel && i_htrans[1] && i_hready;
  assign ap_ofs  = {i_haddr[7:2], 2'b00};

  always_comb begin
    status_w = '0;
    status_w[ST_CODE_LSB +: CODE_W] = code_r;
    status_w[ST_DIG_BIT]  = dig_en_r;
    status_w[ST_ACT_BIT]  = active_r;
    status_w[ST_OVP_BIT]  = ovp_lvl;
    status_w[ST_UVLO_BIT] = uvlo_lvl;
    status_w[ST_HOT_BIT]  = hot_lvl;
    status_w[ST_SW_BIT]   = o_switch_gate_en;
    status_w[ST_LED_BIT]  = o_led_current_on;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dp_wr_r  <= 1'b0;
      dp_ofs_r <= '0;
    end else begin
      dp_wr_r  <= ap_take && i_hwrite && (i_haddr[31:8] == 24'h0);
      dp_ofs_r <= ap_ofs;
    end
  end

  // Read data is chosen at the address phase so it stands in the data phase.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_hrdata <= '0;
    end else if (ap_take && !i_hwrite && i_haddr[31:8] == 24'h0) begin
      case (ap_ofs)
        CTRL_OFS:   o_hrdata <= {30'h0, ctrl_r};
        STATUS_OFS: o_hrdata <= status_w;
        COUNT_OFS:  o_hrdata <= {8'h0, ign_cnt_r, dn_cnt_r, up_cnt_r};
        default:    o_hrdata <= '0;
      endcase
    end else begin
      o_hrdata <= '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= CTRL_RESET;
    end else if (dp_wr_r && dp_ofs_r == CTRL_OFS) begin
      ctrl_r <= i_hwdata[1:0];
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

endmodule : led_pulse_ctrl

// *** verilog/led_pkg.sv ***
// Purpose: Shared constants for the LED brightness pulse interface.
// Assumes: 25 MHz core clock; AHB-Lite register access, word aligned.
// Notes:   Times keep their printed unit; cycle counts derive from them.
package led_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CODE_W = 5;
  localparam int TGT_W  = 6;

  // Step windows and timeouts, in their printed units.
  localparam int UP_MIN_NS   = 1_000;
  localparam int UP_MAX_NS   = 75_000;
  localparam int DN_MIN_NS   = 180_000;
  localparam int DN_MAX_NS   = 300_000;
  localparam int DIS_MIN_NS  = 550_000;
  localparam int SHUT_MIN_MS = 50;

  // The up-step least time rounds up; all other times round down.
  localparam int UP_MIN_CYC  = (UP_MIN_NS * 25 + 999) / 1000;
  localparam int UP_MAX_CYC  = (UP_MAX_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int DN_MIN_CYC  = (DN_MIN_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int DN_MAX_CYC  = (DN_MAX_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int DIS_MIN_CYC = (DIS_MIN_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int SHUT_CYC    = SHUT_MIN_MS * (CLK_HZ / 1000);

  // Brightness code values and the full-scale target level.
  localparam logic [CODE_W-1:0] CODE_MID = 5'h10;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h1f;
  localparam logic [CODE_W-1:0] CODE_MIN = 5'h00;
  localparam logic [TGT_W-1:0]  TGT_FULL = 6'h20;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS  = 8'h08;

  // Control register fields and reset value.
  localparam int CTRL_HOLD_OFF_BIT = 0;
  localparam int CTRL_LOCK_BIT     = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register field positions.
  localparam int ST_CODE_LSB = 0;
  localparam int ST_DIG_BIT  = 8;
  localparam int ST_ACT_BIT  = 9;
  localparam int ST_OVP_BIT  = 10;
  localparam int ST_UVLO_BIT = 11;
  localparam int ST_HOT_BIT  = 12;
  localparam int ST_SW_BIT   = 13;
  localparam int ST_LED_BIT  = 14;

  // Event counter field positions.
  localparam int CNT_UP_LSB  = 0;
  localparam int CNT_DN_LSB  = 8;
  localparam int CNT_IGN_LSB = 16;

  typedef enum logic [2:0] {
    STEP_NONE = 3'b001,
    STEP_UP   = 3'b010,
    STEP_DOWN = 3'b100
  } step_t;

endpackage : led_pkg

// *** verilog/pin_sync_if.sv ***
// Purpose: Carries one pin from the top to its input filter and back.
// Assumes: Same clock on both sides.
// Notes:   Edge strobes are single-cycle pulses.
`timescale 1ns/1ns
interface pin_sync_if;
  logic raw;
  logic level;
  logic rise;
  logic fall;
  modport filt (input raw, output level, rise, fall);
  modport user (output raw, input level, rise, fall);
endinterface : pin_sync_if

// *** verilog/pin_filter.sv ***
// Purpose: Three-stage synchroniser with agreement on the last two stages.
// Assumes: Raw pin is asynchronous to i_clk.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ns
module pin_filter
  import led_pkg::*;
(
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Pin path.
  pin_sync_if.filt  pin
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic rise_r;
  logic fall_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts only once the last two stages agree.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      level_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      rise_r  <= (s2_r == s3_r) && s3_r && !level_r;
      fall_r  <= (s2_r == s3_r) && !s3_r && level_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign pin.level = level_r;
  assign pin.rise  = rise_r;
  assign pin.fall  = fall_r;

endmodule : pin_filter

// *** dv/led_pulse_ctrl_asserts.sv ***
// Purpose: Port assertions for the LED pulse controller.
// Assumes: A level held eight edges has crossed the input synchroniser.
// Notes:   Counters stand in for waits longer than eight edges.
`timescale 1ns/1ns
module led_pulse_ctrl_asserts
  import led_pkg::*;
#(
  parameter int DIS_MIN = DIS_MIN_CYC,
  parameter int SHUT    = SHUT_CYC
) (
  // Clock, reset and pins.
  input wire logic             i_clk,
  input wire logic             i_reset,
  input wire logic             i_brightness_program_pin,
  input wire logic             i_enable_pin,
  input wire logic             i_output_overvoltage_guard,
  input wire logic             i_undervoltage,
  input wire logic             i_over_temperature,
  // Power stage and reference.
  input wire logic [TGT_W-1:0] o_feedback_target_level,
  input wire logic             o_switch_gate_en,
  input wire logic             o_power_switches_off,
  input wire logic             o_led_current_on
);
  int              pin_lo_r;
  int              en_lo_r;
  wire [TGT_W-1:0] tgt = o_feedback_target_level;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  always_ff @(posedge i_clk) begin
    pin_lo_r <= (i_reset || i_brightness_program_pin) ? 0 : pin_lo_r + 1;
  end
  always_ff @(posedge i_clk) begin
    en_lo_r <= (i_reset || i_enable_pin) ? 0 : en_lo_r + 1;
  end
  AST_OVP_STOP:
    assert property (i_output_overvoltage_guard [*8] |-> !o_switch_gate_en)
    else $error("switching in overvoltage");
  AST_UVLO_OFF:
    assert property (i_undervoltage [*8] |->
      o_power_switches_off && !o_switch_gate_en)
    else $error("switches on in undervoltage");
  AST_HOT_OFF:
    assert property (i_over_temperature [*8] |-> o_power_switches_off)
    else $error("switches on when hot");
  AST_LED_EN:
    assert property ((!i_enable_pin) [*8] |-> !o_led_current_on)
    else $error("LED current with enable low");
  AST_ONE_STEP:
    assert property ($changed(tgt) && tgt != TGT_FULL
      && $past(tgt) != TGT_FULL |-> tgt == $past(tgt) + 6'h1
      || tgt + 6'h1 == $past(tgt))
    else $error("target moved more than one step");
  AST_MID_START:
    assert property ($past(tgt) == TGT_FULL && tgt != TGT_FULL
      |-> tgt == 6'h10)
    else $error("control did not start at midpoint");
  AST_LONG_LOW:
    assert property (pin_lo_r > DIS_MIN + 8 |-> tgt == TGT_FULL)
    else $error("long low kept digital control");
  AST_SHUTDOWN:
    assert property (en_lo_r > SHUT + 12 |->
      !o_switch_gate_en && tgt == TGT_FULL)
    else $error("switching or digital control after shutdown time");
endmodule : led_pulse_ctrl_asserts

bind led_pulse_ctrl led_pulse_ctrl_asserts #(.DIS_MIN(DIS_MIN), .SHUT(SHUT))
  u_asserts (.i_clk(i_clk), .i_reset(i_reset),
  .i_brightness_program_pin(i_brightness_program_pin),
  .i_enable_pin(i_enable_pin),
  .i_output_overvoltage_guard(i_output_overvoltage_guard),
  .i_undervoltage(i_undervoltage), .i_over_temperature(i_over_temperature),
  .o_feedback_target_level(o_feedback_target_level),
  .o_switch_gate_en(o_switch_gate_en),
  .o_power_switches_off(o_power_switches_off),
  .o_led_current_on(o_led_current_on));

// *** dv/host_pin_model.sv ***
// Purpose: Host side model driving the program and enable pins.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   Tie mode puts the program line on the enable pin as well.
`timescale 1ns/1ns
module host_pin_model (
  // Clock and mode.
  input  wire logic i_clk,
  input  wire logic i_tie,
  // Pins.
  output logic      o_program_pin,
  output logic      o_enable_pin
);
  logic prog_r = 1'b0;
  logic en_r   = 1'b0;
  assign o_program_pin = prog_r;
  assign o_enable_pin  = i_tie ? prog_r : en_r;
  task automatic pulse(input int low_cyc);
    prog_r <= 1'b0;
    repeat (low_cyc) @(posedge i_clk);
    prog_r <= 1'b1;
    repeat (40) @(posedge i_clk);
  endtask : pulse
  task automatic drive(input logic p, input logic e, input int hold);
    prog_r <= p;
    en_r <= e;
    repeat (hold) @(posedge i_clk);
  endtask : drive
endmodule : host_pin_model

// *** dv/tb_led_brightness_pulse_interface.sv ***
// Purpose: Self-checking bench for the LED brightness pulse interface.
// Assumes: Down, disable and shutdown counts shortened by parameter.
// Notes:   Down steps dominate run time, so few of them are random.
`timescale 1ns/1ns
module tb_led_brightness_pulse_interface;
  import led_pkg::*;
  localparam int DN0 = 2000;
  localparam int DIS = 3000;
  localparam int SHT = 4000;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hready;
  logic        hresp;
  logic        tie = 1'b0;
  logic [2:0]  flt = 3'h0;
  logic        prog;
  logic        en;
  logic [5:0]  tgt;
  logic        gate;
  logic        sw_off;
  logic        led;
  logic [4:0]  code;
  int          num_errors = 0;
  int          checks = 0;
  int          n_up = 0;
  int          n_dn = 0;
  int          n_ign = 0;
  int          seed = 32'h88c98175;
  led_pulse_ctrl #(.DN_MIN(DN0), .DN_MAX(2500), .DIS_MIN(DIS), .SHUT(SHT))
    DUT (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_brightness_program_pin(prog),
    .i_enable_pin(en), .i_output_overvoltage_guard(flt[0]),
    .i_undervoltage(flt[1]), .i_over_temperature(flt[2]),
    .o_feedback_target_level(tgt), .o_switch_gate_en(gate),
    .o_power_switches_off(sw_off), .o_led_current_on(led));
  host_pin_model HOST (.i_clk(i_clk), .i_tie(tie), .o_program_pin(prog),
    .o_enable_pin(en));
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Widths keep a margin from each window edge for synchroniser slack.
  function automatic int width(input int k);
    int r;
    r = $unsigned($random(seed)) % 100;
    case (k)
      0: return 27 + r * 18;
      1: return DN0 + 2 + r * 4;
      2: return 1880 + r;
      default: return 2505 + r * 4;
    endcase
  endfunction : width
  function automatic logic [4:0] nxt(input logic [4:0] c, input int w);
    if (w <= UP_MAX_CYC && c != CODE_MAX) return c + 5'h1;
    if (w >= DN0 && w <= 2500 && c != CODE_MIN) return c - 5'h1;
    return c;
  endfunction : nxt
  task automatic step(input int w);
    HOST.pulse(w);
    code = nxt(code, w);
    if (w <= UP_MAX_CYC) n_up++;
    else if (w >= DN0 && w <= 2500) n_dn++;
    else n_ign++;
    chk("target", {27'h0, code}, {26'h0, tgt});
  endtask : step
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk("full", 32'h20, {26'h0, tgt});
    bus(1'b1, 32'(CTRL_OFS), 32'h2);
    // An alias of the control word would read back nonzero here.
    bus(1'b0, 32'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, 32'(CTRL_OFS), 32'h0);
    chk("ctrl", 32'h2, rd);
    HOST.drive(1'b1, 1'b1, 40);
    code = CODE_MID;
    chk("mid", 32'h10, {26'h0, tgt});
    HOST.pulse(27);
    n_ign++;
    chk("locked", 32'h10, {26'h0, tgt});
    bus(1'b1, 32'(CTRL_OFS), 32'h0);
    for (int i = 0; i < 17; i++) step(width(1));
    repeat (12) step(width($unsigned($random(seed)) % 4));
    repeat (33) step(27);
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    chk("status", {27'h0, code}, {27'h0, rd[4:0]});
    chk("hresp", 32'h0, {31'h0, hresp});
    HOST.drive(1'b0, 1'b1, DIS + 20);
    chk("disable", 32'h20, {26'h0, tgt});
    HOST.drive(1'b1, 1'b1, 40);
    code = CODE_MID;
    chk("restart", 32'h10, {26'h0, tgt});
    tie <= 1'b1;
    step(1870);
    tie <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      flt <= 3'h1 << k;
      repeat (10) @(posedge i_clk);
      chk("gate_off", 32'h0, {31'h0, gate});
      chk("sw_off", {31'h0, k != 0}, {31'h0, sw_off});
      flt <= 3'h0;
      repeat (10) @(posedge i_clk);
      chk("gate_on", 32'h1, {31'h0, gate});
    end
    HOST.drive(1'b1, 1'b0, 100);
    chk("led_off", 32'h0, {31'h0, led});
    HOST.drive(1'b1, 1'b1, 20);
    chk("led_on", 32'h1, {31'h0, led});
    chk("kept", {27'h0, code}, {26'h0, tgt});
    HOST.drive(1'b1, 1'b0, SHT + 20);
    chk("shut", 32'h0, {31'h0, gate});
    chk("shut_tgt", 32'h20, {26'h0, tgt});
    // Hold-off keeps the device asleep although enable returns high.
    bus(1'b1, 32'(CTRL_OFS), 32'h1);
    HOST.drive(1'b1, 1'b1, 20);
    chk("held_gate", 32'h0, {31'h0, gate});
    bus(1'b0, 32'(STATUS_OFS), 32'h0);
    chk("held_act", 32'h0, {31'h0, rd[ST_ACT_BIT]});
    bus(1'b1, 32'(CTRL_OFS), 32'h0);
    HOST.drive(1'b1, 1'b1, 20);
    chk("wake", 32'h10, {26'h0, tgt});
    bus(1'b0, 32'(COUNT_OFS), 32'h0);
    chk("count", {8'h0, 8'(n_ign), 8'(n_dn), 8'(n_up)}, rd);
    end_of_test();
  end
endmodule : tb_led_brightness_pulse_interface
